/* hw/fdl_consts.svh */
// fast-detect constants: register byte offsets, field positions, reset values, latencies
// assumes inclusion by bare name from the fast-detect design files
//
// Notes on behaviour
// - overrange flag high while magnitude exceeds the programmed threshold, else low
// - traditional mode flags 14-bit codes 1fff, 2000 and 2001, all of magnitude 1fff
// - all threshold decisions use magnitude only, sign ignored
// - four pins per channel, 3-bit mode at ctrl[3:1] plus enable bit
// - mode 000 shows 4-bit magnitude; mode 001 3-bit magnitude plus overrange
// - modes 010/011 show 2-bit magnitude on pins 2:1 plus two flags
// - mode 000 with single-ended outputs has two cycles pin latency
// - differential output format gives six cycles pin latency in every mode
// - modes 001-011 six cycles latency, larger of each sample pair shown
// - 4-bit magnitude codes 0000 to 1000 only, higher codes unused
// - 3-bit magnitude codes 000 to 111, top code reaches full scale
// - 2-bit magnitude is the 3-bit code without its least significant bit
// - overrange flag taken from converter pipeline output, 12 cycles after input
// - coarse-upper flag two cycles after level exceeded, held at least two cycles
// - gain-increase only after magnitude stays below fine-lower for the dwell count
`ifndef FDL_CONSTS_SVH
`define FDL_CONSTS_SVH

`define FDL_ADDR_CTRL 8'h00
`define FDL_ADDR_CUT 8'h04
`define FDL_ADDR_FUT 8'h08
`define FDL_ADDR_FLT 8'h0c
`define FDL_ADDR_DWELL 8'h10
`define FDL_ADDR_ORTH 8'h14
`define FDL_ADDR_STAT 8'h18
`define FDL_ADDR_MASK 8'h1c
`define FDL_ADDR_LIVE 8'h20

`define FDL_CTRL_EN 0
`define FDL_CTRL_LVDS 4
`define FDL_CTRL_TRAD 5
`define FDL_CTRL_RST 6'h00
`define FDL_CUT_RST 3'h7
`define FDL_FUT_RST 13'h1fff
`define FDL_FLT_RST 13'h0000
`define FDL_DWELL_RST 16'h0001
`define FDL_ORTH_RST 13'h1fff
`define FDL_STAT_RST 4'h0
`define FDL_MASK_RST 4'h0

`define FDL_LAT_SHORT 2
`define FDL_LAT_LONG 6
`define FDL_FM_MAX 4'h8
`define FDL_FM3_MAX 3'h7
`define FDL_MAG_MAX 13'h1fff
`define FDL_POS_FS 14'h1fff
`define FDL_NEG_FS 14'h2000
`define FDL_DWELL_SAT 16'hffff

`endif

/* hw/fdl_lat_pipe.sv */
// fast-detect pin latency line and output stage for one channel
// assumes pin_word is built on pclk from the same channel's detectors
`include "fdl_consts.svh"

module fdl_lat_pipe (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin word and control
    input wire logic [3:0] pin_word,
    input wire logic long_lat,
    input wire logic fd_enable,
    // pins
    output logic [3:0] fast_level_pins
);
    logic [3:0] stage_reg [0:`FDL_LAT_LONG-2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_reg[0] <= 4'h0;
        end else begin
            stage_reg[0] <= pin_word;
        end
    end

    genvar k;
    generate
        for (k = 1; k < `FDL_LAT_LONG-1; k++) begin : g_stage
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage_reg[k] <= 4'h0;
                end else begin
                    stage_reg[k] <= stage_reg[k-1];
                end
            end
        end
    endgenerate

    // one extra flop keeps pins glitch free across mode changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_level_pins <= 4'h0;
        end else if (!fd_enable) begin
            fast_level_pins <= 4'h0;
        end else if (long_lat) begin
            fast_level_pins <= stage_reg[`FDL_LAT_LONG-2];
        end else begin
            fast_level_pins <= stage_reg[`FDL_LAT_SHORT-2];
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    pins_off_a: assert property (!fd_enable |=> fast_level_pins == 4'h0)
        else $error("pins not low while fast detect disabled");

    short_lat_a: assert property ((fd_enable && !long_lat) [*3]
        |-> fast_level_pins == $past(pin_word, 2))
        else $error("short pin latency is not two cycles");

    long_lat_a: assert property ((fd_enable && long_lat) [*7]
        |-> fast_level_pins == $past(pin_word, 6))
        else $error("long pin latency is not six cycles");
endmodule : fdl_lat_pipe

/* hw/fdl_pkg.sv */
// fast-detect shared types
// assumes nothing beyond a SystemVerilog compiler
package fdl_pkg;
    typedef enum logic [2:0] {
        fdl_mag4,
        fdl_mag3_or,
        fdl_mag2_or_flt,
        fdl_mag2_cut_flt,
        fdl_flags,
        fdl_gain
    } fdl_mode_t;
endpackage : fdl_pkg

/* hw/fdl_top.sv */
// fast-detect level mux for two converter channels with APB registers
// assumes samples and coarse magnitudes arrive on pclk; output data clock is asynchronous
//
// Design decisions made here: the register addresses and register access over APB.
`include "fdl_consts.svh"

module fdl_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter side, one entry per channel
    input wire logic [1:0][13:0] sample,
    input wire logic [1:0][3:0] coarse_mag,
    // output data clock from the link side
    input wire logic output_data_clock,
    // pins and interrupt
    output logic [1:0][3:0] fast_level_pins,
    output logic irq
);
    // register file
    logic [5:0] ctrl_reg;
    logic [2:0] cut_reg;
    logic [12:0] fut_reg;
    logic [12:0] flt_reg;
    logic [15:0] dwell_reg;
    logic [12:0] orth_reg;
    logic [3:0] status_reg;
    logic [3:0] status_next;
    logic [3:0] mask_reg;
    logic [31:0] rdata_next;
    logic err_next;

    // bus phases
    logic setup_ph;
    logic wr_acc;
    logic rd_acc;
    logic stat_rd;

    // link clock sampling
    logic odc_s1;
    logic odc_s2;
    logic odc_s3;
    logic pair_tick;

    // per-channel results
    logic [1:0] or_flag;
    logic [1:0] or_prev;
    logic [1:0] ig_flag;
    logic [1:0] ig_prev;
    logic [3:0] ev_vec;

    fdl_pkg::fdl_mode_t mode;
    logic fd_enable;
    logic lvds_fmt;
    logic or_trad;
    logic [15:0] dwell_eff;

    assign mode = fdl_pkg::fdl_mode_t'(ctrl_reg[3:1]);
    assign fd_enable = ctrl_reg[`FDL_CTRL_EN];
    assign lvds_fmt = ctrl_reg[`FDL_CTRL_LVDS];
    assign or_trad = ctrl_reg[`FDL_CTRL_TRAD];
    // a zero dwell would mean no wait at all; treat it as one cycle
    assign dwell_eff = (dwell_reg == 16'h0000) ? 16'h0001 : dwell_reg;

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign stat_rd = rd_acc && (paddr == `FDL_ADDR_STAT);
    assign pready = 1'b1;

    // output data clock: two flops, then an edge detector on the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            odc_s1 <= 1'b0;
            odc_s2 <= 1'b0;
            odc_s3 <= 1'b0;
        end else begin
            odc_s1 <= output_data_clock;
            odc_s2 <= odc_s1;
            odc_s3 <= odc_s2;
        end
    end

    // one tick per output data clock period, on its rising edge
    assign pair_tick = odc_s2 && !odc_s3;

    // register writes take effect at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `FDL_CTRL_RST;
            cut_reg <= `FDL_CUT_RST;
            fut_reg <= `FDL_FUT_RST;
            flt_reg <= `FDL_FLT_RST;
            dwell_reg <= `FDL_DWELL_RST;
            orth_reg <= `FDL_ORTH_RST;
            mask_reg <= `FDL_MASK_RST;
        end else if (wr_acc) begin
            if (paddr == `FDL_ADDR_CTRL) begin
                ctrl_reg <= pwdata[5:0];
            end else if (paddr == `FDL_ADDR_CUT) begin
                cut_reg <= pwdata[2:0];
            end else if (paddr == `FDL_ADDR_FUT) begin
                fut_reg <= pwdata[12:0];
            end else if (paddr == `FDL_ADDR_FLT) begin
                flt_reg <= pwdata[12:0];
            end else if (paddr == `FDL_ADDR_DWELL) begin
                dwell_reg <= pwdata[15:0];
            end else if (paddr == `FDL_ADDR_ORTH) begin
                orth_reg <= pwdata[12:0];
            end else if (paddr == `FDL_ADDR_MASK) begin
                mask_reg <= pwdata[3:0];
            end
        end
    end

    // read mux, sampled in the setup cycle so the access cycle needs no wait
    always_comb begin
        rdata_next = 32'h0000_0000;
        err_next = 1'b0;
        if (paddr == `FDL_ADDR_CTRL) begin
            rdata_next[5:0] = ctrl_reg;
        end else if (paddr == `FDL_ADDR_CUT) begin
            rdata_next[2:0] = cut_reg;
        end else if (paddr == `FDL_ADDR_FUT) begin
            rdata_next[12:0] = fut_reg;
        end else if (paddr == `FDL_ADDR_FLT) begin
            rdata_next[12:0] = flt_reg;
        end else if (paddr == `FDL_ADDR_DWELL) begin
            rdata_next[15:0] = dwell_reg;
        end else if (paddr == `FDL_ADDR_ORTH) begin
            rdata_next[12:0] = orth_reg;
        end else if (paddr == `FDL_ADDR_STAT) begin
            rdata_next[3:0] = status_reg;
        end else if (paddr == `FDL_ADDR_MASK) begin
            rdata_next[3:0] = mask_reg;
        end else if (paddr == `FDL_ADDR_LIVE) begin
            rdata_next[11:0] = {ig_flag, or_flag, fast_level_pins};
        end else begin
            err_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata <= pwrite ? 32'h0000_0000 : rdata_next;
            pslverr <= err_next;
        end
    end

    // events: rising overrange and rising gain-increase, per channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            or_prev <= 2'h0;
            ig_prev <= 2'h0;
        end else begin
            or_prev <= or_flag;
            ig_prev <= ig_flag;
        end
    end

    assign ev_vec = {ig_flag & ~ig_prev, or_flag & ~or_prev};

    // only the bits that went out on the bus are cleared, so an event
    // landing between setup and access is kept; a same-edge set wins
    always_comb begin
        status_next = status_reg;
        if (stat_rd) begin
            status_next = status_reg & ~prdata[3:0];
        end
        status_next = status_next | ev_vec;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= `FDL_STAT_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    assign irq = |(status_reg & mask_reg);

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            logic [13:0] abs_full;
            logic [12:0] mag;
            logic over_raw;
            logic [3:0] fm4;
            logic [2:0] fm3;
            logic [3:0] fm_prev;
            logic [3:0] pair_mag;
            logic [2:0] pair3;
            logic cut_raw;
            logic cut_d1;
            logic cut_flag;
            logic cut_flag_q;
            logic fut_flag;
            logic flt_flag;
            logic below;
            logic [15:0] dwell_cnt;
            logic [16:0] cnt_inc;
            logic [3:0] pin_word;
            logic long_lat;

            // magnitude only; the most negative code saturates to full scale
            assign abs_full = sample[g][13] ? 14'(~sample[g] + 14'h0001) : sample[g];
            assign mag = abs_full[13] ? `FDL_MAG_MAX : abs_full[12:0];

            // both full-scale codes give the saturated magnitude
            assign over_raw = or_trad ? (mag == `FDL_MAG_MAX)
                                      : (mag > orth_reg);

            // sample input is already the pipeline output, so no extra delay
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    or_flag[g] <= 1'b0;
                end else begin
                    or_flag[g] <= over_raw;
                end
            end

            assign fm4 = (coarse_mag[g] > `FDL_FM_MAX) ? `FDL_FM_MAX : coarse_mag[g];
            assign fm3 = fm4[3] ? `FDL_FM3_MAX : fm4[2:0];

            // coarse upper: two flops of delay, then a one-cycle stretch
            assign cut_raw = fm3 > cut_reg;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cut_d1 <= 1'b0;
                    cut_flag <= 1'b0;
                    cut_flag_q <= 1'b0;
                end else begin
                    cut_d1 <= cut_raw;
                    cut_flag <= cut_d1 || (cut_flag && !cut_flag_q);
                    cut_flag_q <= cut_flag;
                end
            end

            assign below = mag < flt_reg;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fut_flag <= 1'b0;
                    flt_flag <= 1'b0;
                end else begin
                    fut_flag <= mag > fut_reg;
                    flt_flag <= below;
                end
            end

            // dwell counter saturates so a long quiet stretch keeps the flag up
            assign cnt_inc = {1'b0, dwell_cnt} + 17'h0_0001;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dwell_cnt <= 16'h0000;
                    ig_flag[g] <= 1'b0;
                end else begin
                    if (!below) begin
                        dwell_cnt <= 16'h0000;
                    end else if (dwell_cnt != `FDL_DWELL_SAT) begin
                        dwell_cnt <= cnt_inc[15:0];
                    end
                    ig_flag[g] <= below && (cnt_inc >= {1'b0, dwell_eff});
                end
            end

            // larger of each sample pair, refreshed once per output clock period
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fm_prev <= 4'h0;
                    pair_mag <= 4'h0;
                end else begin
                    fm_prev <= fm4;
                    if (pair_tick) begin
                        pair_mag <= (fm4 > fm_prev) ? fm4 : fm_prev;
                    end
                end
            end
            assign pair3 = pair_mag[3] ? `FDL_FM3_MAX : pair_mag[2:0];

            always_comb begin
                case (mode)
                    fdl_pkg::fdl_mag4: pin_word = fm4;
                    fdl_pkg::fdl_mag3_or: pin_word = {pair3, or_flag[g]};
                    fdl_pkg::fdl_mag2_or_flt: pin_word = {or_flag[g], pair3[2:1], flt_flag};
                    fdl_pkg::fdl_mag2_cut_flt: pin_word = {cut_flag, pair3[2:1], flt_flag};
                    fdl_pkg::fdl_flags: pin_word = {or_flag[g], cut_flag, fut_flag, flt_flag};
                    fdl_pkg::fdl_gain: pin_word = {or_flag[g], fut_flag, ig_flag[g], cut_flag};
                    default: pin_word = 4'h0;
                endcase
            end

            assign long_lat = lvds_fmt || (mode != fdl_pkg::fdl_mag4);

            fdl_lat_pipe u_pipe (
                .pclk(pclk),
                .presetn(presetn),
                .pin_word(pin_word),
                .long_lat(long_lat),
                .fd_enable(fd_enable),
                .fast_level_pins(fast_level_pins[g])
            );

            cut_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
                cut_raw |-> ##2 cut_flag)
                else $error("coarse upper flag not two cycles after level");

            cut_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
                $rose(cut_flag) |=> cut_flag)
                else $error("coarse upper flag shorter than two cycles");

            ig_dwell_a: assert property (@(posedge pclk) disable iff (!presetn)
                ig_flag[g] |-> $past(below) && ($past(cnt_inc) >= {1'b0, $past(dwell_eff)}))
                else $error("gain increase before dwell elapsed");

            or_low_a: assert property (@(posedge pclk) disable iff (!presetn)
                (!or_trad && mag <= orth_reg) |=> !or_flag[g])
                else $error("overrange flag high below threshold");

            or_fs_a: assert property (@(posedge pclk) disable iff (!presetn)
                (or_trad && (sample[g] == `FDL_POS_FS || sample[g] == `FDL_NEG_FS))
                |=> or_flag[g])
                else $error("full-scale overflow not flagged");
        end
    endgenerate

    stat_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        stat_rd |=> status_reg == (($past(status_reg) & ~$past(prdata[3:0])) | $past(ev_vec)))
        else $error("status read clear lost or kept a bit");

    irq_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (irq && !stat_rd && !(wr_acc && paddr == `FDL_ADDR_MASK)) |=> irq)
        else $error("interrupt dropped without a status read");
endmodule : fdl_top

/* sim/fdl_gain_model.sv */
// far-side gain control model: makes the link clock and captures the pins
// assumes the link clock runs free with a 400 ns period, phase unrelated to pclk
module fdl_gain_model (
    // link clock
    output logic output_data_clock,
    // pins and captures
    input wire logic [1:0][3:0] fast_level_pins,
    output logic [1:0][3:0] rise_cap,
    output logic [1:0][3:0] fall_cap
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        output_data_clock = 1'b0;
        #137;
        forever #200 output_data_clock = ~output_data_clock;
    end

    // both edges, since each half period carries its own value
    always @(posedge output_data_clock) rise_cap <= fast_level_pins;
    always @(negedge output_data_clock) fall_cap <= fast_level_pins;
endmodule : fdl_gain_model

/* sim/testbench.sv */
// self-checking bench for the fast-detect level mux
// assumes apb with any number of waits and the gain model as link clock source
`include "fdl_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [5:0] ctrl;
        logic [3:0] crs;
        logic [13:0] smp;
        logic [3:0] pins;
    } fdl_row_t;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0][13:0] sample = 28'h000_0000;
    logic [1:0][3:0] coarse_mag = 8'h00;
    logic output_data_clock;
    logic [1:0][3:0] fast_level_pins;
    logic [1:0][3:0] rise_cap;
    logic [1:0][3:0] fall_cap;
    logic irq;
    logic [31:0] rd;
    logic er;
    int bad_count = 0;
    int cmp_count = 0;
    int hi;
    logic [31:0] rv [8] = '{32'h0, 32'h7, 32'h1fff, 32'h0, 32'h1, 32'h1fff, 32'h0, 32'h0};
    // ctrl, coarse, sample, pins; thresholds cut 3, fut 1000, flt 500, orth 4000
    fdl_row_t rows [14] = '{
        '{6'h01, 4'h9, 14'h0000, 4'h8}, '{6'h01, 4'h5, 14'h0064, 4'h5},
        '{6'h03, 4'h7, 14'h2c78, 4'hf}, '{6'h03, 4'h8, 14'h0064, 4'he},
        '{6'h05, 4'h6, 14'h0064, 4'h7}, '{6'h07, 4'h5, 14'h0bb8, 4'hc},
        '{6'h09, 4'h2, 14'h2e6c, 4'ha}, '{6'h0b, 4'h4, 14'h00c8, 4'h3},
        '{6'h0d, 4'h4, 14'h2e6c, 4'h0}, '{6'h11, 4'h6, 14'h0064, 4'h6},
        '{6'h00, 4'h5, 14'h2c78, 4'h0}, '{6'h23, 4'h3, 14'h1fff, 4'h7},
        '{6'h23, 4'h3, 14'h1ffe, 4'h6}, '{6'h23, 4'h3, 14'h2000, 4'h7}};

    always #25 pclk = ~pclk;

    fdl_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample(sample), .coarse_mag(coarse_mag),
        .output_data_clock(output_data_clock), .fast_level_pins(fast_level_pins),
        .irq(irq));

    fdl_gain_model partner (.output_data_clock(output_data_clock),
        .fast_level_pins(fast_level_pins), .rise_cap(rise_cap), .fall_cap(fall_cap));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no fixed wait assumed; only the watchdog ends a hung access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic drive(input logic [3:0] c, input logic [13:0] s);
        @(posedge pclk);
        coarse_mag <= {c, c};
        sample <= {s, s};
    endtask : drive

    task automatic lat(input logic [5:0] c, input int n);
        apb(1'b1, `FDL_ADDR_CTRL, 32'(c));
        drive(4'h0, 14'h0000);
        repeat (20) @(posedge pclk);
        coarse_mag <= 8'h55;
        repeat (n - 1) @(posedge pclk);
        #1 chk("pins early", 32'h0, 32'(fast_level_pins));
        @(posedge pclk);
        #1 chk("pins due", 32'h55, 32'(fast_level_pins));
    endtask : lat

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // a full run takes well under 200 us
    initial begin
        #1000000;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        #1 chk("pins at reset", 32'h0, 32'(fast_level_pins));
        chk("irq at reset", 32'h0, 32'(irq));
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", rv[i], rd);
            chk("mapped err", 32'h0, 32'(er));
        end
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped err", 32'h1, 32'(er));
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, `FDL_ADDR_CUT, 32'h3);
        apb(1'b1, `FDL_ADDR_FUT, 32'h3e8);
        apb(1'b1, `FDL_ADDR_FLT, 32'h1f4);
        apb(1'b1, `FDL_ADDR_DWELL, 32'h4);
        apb(1'b1, `FDL_ADDR_ORTH, 32'hfa0);
        foreach (rows[i]) begin
            apb(1'b1, `FDL_ADDR_CTRL, 32'(rows[i].ctrl));
            drive(rows[i].crs, rows[i].smp);
            repeat (40) @(posedge pclk);
            // all six modes, clamp, sign, traditional and disabled cases
            #1 chk("pins", 32'({2{rows[i].pins}}), 32'(fast_level_pins));
            chk("rise capture", 32'({2{rows[i].pins}}), 32'(rise_cap));
            chk("fall capture", 32'({2{rows[i].pins}}), 32'(fall_cap));
        end
        lat(6'h01, 2);
        lat(6'h11, 6);
        apb(1'b1, `FDL_ADDR_CTRL, 32'h9);
        drive(4'h0, 14'h0bb8);
        repeat (20) @(posedge pclk);
        coarse_mag <= 8'h77;
        @(posedge pclk);
        coarse_mag <= 8'h00;
        hi = 0;
        repeat (20) begin
            @(posedge pclk);
            #1 if (fast_level_pins[0][2] === 1'b1) hi++;
        end
        chk("coarse flag width", 32'h2, 32'(hi));
        // alternating coarse codes: only the larger of each pair may show
        apb(1'b1, `FDL_ADDR_CTRL, 32'h3);
        hi = 0;
        for (int i = 0; i < 40; i++) begin
            @(posedge pclk);
            coarse_mag <= (i % 2 == 1) ? 8'h22 : 8'h66;
            #1 if (i > 24 && fast_level_pins !== 8'hcc) hi++;
        end
        chk("pair maximum", 32'h0, 32'(hi));
        apb(1'b1, `FDL_ADDR_DWELL, 32'h28);
        apb(1'b1, `FDL_ADDR_CTRL, 32'hb);
        drive(4'h0, 14'h0bb8);
        repeat (20) @(posedge pclk);
        drive(4'h0, 14'h0064);
        repeat (8) @(posedge pclk);
        apb(1'b0, `FDL_ADDR_LIVE, 32'h0);
        chk("gain up early", 32'h0, 32'(rd[11:10]));
        repeat (60) @(posedge pclk);
        apb(1'b0, `FDL_ADDR_LIVE, 32'h0);
        chk("gain up late", 32'h3, 32'(rd[11:10]));
        apb(1'b1, `FDL_ADDR_MASK, 32'h1);
        drive(4'h0, 14'h0bb8);
        apb(1'b0, `FDL_ADDR_STAT, 32'h0);
        #1 chk("irq idle", 32'h0, 32'(irq));
        drive(4'h0, 14'h2c78);
        repeat (10) @(posedge pclk);
        #1 chk("irq raised", 32'h1, 32'(irq));
        apb(1'b0, `FDL_ADDR_STAT, 32'h0);
        chk("status", 32'h3, rd);
        #1 chk("irq cleared", 32'h0, 32'(irq));
        apb(1'b1, `FDL_ADDR_MASK, 32'h0);
        drive(4'h0, 14'h0bb8);
        drive(4'h0, 14'h2c78);
        repeat (10) @(posedge pclk);
        #1 chk("irq masked", 32'h0, 32'(irq));
        apb(1'b0, `FDL_ADDR_STAT, 32'h0);
        chk("status masked", 32'h3, rd);
        tally_and_finish();
    end
endmodule : testbench
